// file: ciu_clock_delay.sv
// Cache sram clock delay timer for ordinary and fill transactions
`timescale 1ns/1ps
`default_nettype none
`include "ciu_consts.svh"
module ciu_clock_delay (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Delay settings
  input wire logic [1:0] cache_clock_base_delay,
  input wire logic [2:0] fill_clock_delay_offset,
  // Transaction start
  input wire logic index_start,
  input wire logic fill_cmd,
  // Clock pulse out
  output logic cache_sram_clock
);
  ciu_pkg::ciu_dly_state_t state;
  logic [3:0] count;
  logic [3:0] next_count;

  // Total cycles from index to clock
  always_comb begin
    if (fill_cmd)
      next_count = 4'h1 + {1'b0, fill_clock_delay_offset} + {2'h0, cache_clock_base_delay};
    else
      next_count = {2'h0, cache_clock_base_delay};
  end

  // Count down then pulse the clock N cycles after the index, never sooner than one
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ciu_pkg::CIU_DLY_IDLE;
      count <= 4'h0;
    end else begin
      unique case (state)
        ciu_pkg::CIU_DLY_IDLE: begin
          if (index_start) begin
            count <= next_count - 4'h1;
            state <= (next_count <= 4'h1) ? ciu_pkg::CIU_DLY_CLOCK : ciu_pkg::CIU_DLY_COUNT;
          end
        end
        ciu_pkg::CIU_DLY_COUNT: begin
          count <= count - 4'h1;
          if (count == 4'h1)
            state <= ciu_pkg::CIU_DLY_CLOCK;
        end
        ciu_pkg::CIU_DLY_CLOCK: begin
          state <= ciu_pkg::CIU_DLY_IDLE;
        end
        default: state <= ciu_pkg::CIU_DLY_IDLE;
      endcase
    end
  end

  // Clock pulse from a flip-flop state
  assign cache_sram_clock = (state == ciu_pkg::CIU_DLY_CLOCK);

  // Delay counter loaded only by a start seen in idle
  property p_fill_delay;
    @(posedge core_clk) disable iff (!rstn)
    (state == ciu_pkg::CIU_DLY_IDLE && index_start && fill_cmd
      && cache_clock_base_delay == 2'h1 && fill_clock_delay_offset == 3'h1)
      |-> ##3 cache_sram_clock;
  endproperty
  a_fill_delay: assert property (p_fill_delay) else $error("fill clock delay wrong");

  property p_zero_delay;
    @(posedge core_clk) disable iff (!rstn)
    (state == ciu_pkg::CIU_DLY_IDLE && index_start && !fill_cmd
      && cache_clock_base_delay == 2'h0) |=> cache_sram_clock;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero base delay wrong");
endmodule : ciu_clock_delay
`default_nettype wire

// file: ciu_consts.svh
// Offsets, field positions, reset values and timing of the cache interface unit registers
`ifndef CIU_CONSTS_SVH
`define CIU_CONSTS_SVH
`define CIU_ERROR_ADDRESS_OFFS 40'hFFFFF00088
`define CIU_ERROR_STATUS_OFFS 40'hFFFFF00108
`define CIU_CLK_BASE_LO 14
`define CIU_CLK_BASE_HI 15
`define CIU_FILL_OFF_LO 20
`define CIU_FILL_OFF_HI 22
`define CIU_IO_PAR_EN_BIT 23
`define CIU_MEM_PAR_EN_BIT 24
`define CIU_FORCE_HIT_BIT 25
`define CIU_FORCE_ERR_BIT 26
`define CIU_TAG_DATA_LO 28
`define CIU_TAG_DATA_HI 30
`define CIU_CACHE_EN_BIT 31
`define CIU_CFG_RESET 32'h00104000
`define CIU_CFG_WMASK 32'hF7F0C000
`define CIU_ST_RATIO_LO 4
`define CIU_ST_REV_LO 8
`define CIU_ST_DPE_LO 12
`define CIU_ST_TPE_BIT 16
`define CIU_ST_DIRTY_BIT 17
`define CIU_ST_MEM_BIT 18
`define CIU_ST_MULTI_BIT 19
`define CIU_IO_SPACE_BIT 39
// Arbitrary revision code, not tied to any real part
`define CIU_SILICON_REV 4'hA
// Wait counter value after reset at which the synchronised ratio is taken, on the third edge
`define CIU_RATIO_WAIT 2'h2
`endif

// file: ciu_pkg.sv
// Types shared by the cache interface unit register bank
`default_nettype none
package ciu_pkg;
  typedef enum logic [1:0] {CIU_DLY_IDLE, CIU_DLY_COUNT, CIU_DLY_CLOCK} ciu_dly_state_t;
  typedef logic [3:0] ciu_nibble_t;
endpackage : ciu_pkg
`default_nettype wire

// file: ciu_regs.sv
// Cache interface unit configuration, error address and error status registers
//
// What this block does
// - Fill clock delay is one plus offset plus base
// - Check I/O read parity when enabled
// - Check memory read parity when enabled
// - Force hit on memory space accesses
// - Force error inverts longword bit zero
// - Forced hit writes tag status field
// - Cache enable gates caching and memory writes
// - Error address is read-only captured address
// - Error address keeps bits 36:4, 39
// - Status locks on first error
// - Status read clears status and unlocks both registers; error address keeps its value
// - Clock ratio captured from pins at reset
// - Read-only silicon revision code field
// - One parity flag per data longword
// - Tag parity error flag, never set since tag_err is always zero
// - Low status bits read zero
// - Base clock delay resets to one
// - Capture dirty flag of failing tag
// - Flag errors seen during fill
// - Multiple-error flag while locked
`timescale 1ns/1ps
`default_nettype none
`include "ciu_consts.svh"
module ciu_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Internal register access
  input wire logic [39:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [63:0] reg_rdata,
  // Configuration write port for the configuration register
  input wire logic cfg_wr,
  output logic [31:0] cfg_rdata,
  // Interrupt request pins, sampled for the clock ratio
  input wire logic [3:0] irq_pins,
  // Read data returning from the system
  input wire logic rd_valid,
  input wire logic [39:0] physical_address,
  input wire logic [127:0] rd_data,
  input wire logic [3:0] rd_parity,
  input wire logic rd_fill,
  // Tag store returned for the access
  input wire logic tag_valid,
  input wire logic [2:0] tag_status_in,
  input wire logic tag_match,
  // Access requests
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_instr,
  input wire logic [39:0] acc_address,
  input wire logic [127:0] wr_data_in,
  // Cache control outputs
  output logic cache_hit,
  output logic go_to_memory,
  output logic mem_write_blocked,
  output logic tag_write,
  output logic [2:0] tag_status_out,
  output logic [127:0] wr_data_out,
  // Cache sram clock timing
  input wire logic index_start,
  input wire logic fill_cmd,
  output logic cache_sram_clock
);
  logic [31:0] cfg;
  logic [3:0] irq_meta;
  logic [3:0] irq_sync;
  logic [1:0] ratio_wait;
  ciu_pkg::ciu_nibble_t system_clock_ratio;
  logic [3:0] data_parity_error_flags;
  logic tag_parity_error_flag;
  logic err_dirty;
  logic err_memory;
  logic err_multi;
  logic [39:0] error_address;
  logic locked;
  logic status_read;
  logic addr_read;
  logic check_en;
  logic [3:0] lw_err;
  logic tag_err;
  logic any_err;
  logic [31:0] error_status;
  logic [63:0] error_address_view;

  // Even parity over one longword with its parity bit
  function automatic logic lw_parity_bad(input logic [31:0] d, input logic p);
    lw_parity_bad = ^{d, p};
  endfunction : lw_parity_bad

  // Configuration register, written through its own strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      cfg <= `CIU_CFG_RESET;
    else if (cfg_wr)
      cfg <= reg_wdata & `CIU_CFG_WMASK;
  end
  assign cfg_rdata = cfg;

  // Two-stage synchroniser for the request pins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_meta <= 4'h0;
      irq_sync <= 4'h0;
    end else begin
      irq_meta <= irq_pins;
      irq_sync <= irq_meta;
    end
  end

  // Clock ratio caught once, after the synchroniser has filled behind reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ratio_wait <= 2'h0;
      system_clock_ratio <= 4'h0;
    end else if (ratio_wait != 2'h3) begin
      ratio_wait <= ratio_wait + 2'h1;
      if (ratio_wait == `CIU_RATIO_WAIT)
        system_clock_ratio <= irq_sync;
    end
  end

  // Parity checking of returning read data
  assign check_en = rd_valid && (physical_address[`CIU_IO_SPACE_BIT]
    ? cfg[`CIU_IO_PAR_EN_BIT] : cfg[`CIU_MEM_PAR_EN_BIT]);
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lw
      assign lw_err[gi] = check_en && lw_parity_bad(rd_data[32*gi +: 32], rd_parity[gi]);
      // Forced corruption of bit zero in each written longword
      assign wr_data_out[32*gi +: 32] = {wr_data_in[32*gi+1 +: 31],
        wr_data_in[32*gi] ^ cfg[`CIU_FORCE_ERR_BIT]};
    end
  endgenerate
  assign tag_err = check_en && tag_valid && (^tag_status_in ^ ^physical_address[38:4] ? 1'b0 : 1'b0);
  assign any_err = (|lw_err) || tag_err;

  // Register read decode
  assign status_read = reg_rd && (reg_addr == `CIU_ERROR_STATUS_OFFS);
  assign addr_read = reg_rd && (reg_addr == `CIU_ERROR_ADDRESS_OFFS);

  // Error status capture, lock and clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      data_parity_error_flags <= 4'h0;
      tag_parity_error_flag <= 1'b0;
      err_dirty <= 1'b0;
      err_memory <= 1'b0;
      err_multi <= 1'b0;
      error_address <= 40'h0;
    end else if (any_err && (!locked || status_read)) begin
      data_parity_error_flags <= lw_err;
      tag_parity_error_flag <= tag_err;
      err_dirty <= tag_status_in[0];
      err_memory <= rd_fill;
      err_multi <= 1'b0;
      error_address <= physical_address;
    end else if (any_err) begin
      err_multi <= 1'b1;
    end else if (status_read) begin
      data_parity_error_flags <= 4'h0;
      tag_parity_error_flag <= 1'b0;
      err_dirty <= 1'b0;
      err_memory <= 1'b0;
      err_multi <= 1'b0;
    end
  end
  assign locked = (|data_parity_error_flags) || tag_parity_error_flag;

  // Status word assembly, low bits reserved as zero
  always_comb begin
    error_status = 32'h0;
    error_status[`CIU_ST_RATIO_LO +: 4] = system_clock_ratio;
    error_status[`CIU_ST_REV_LO +: 4] = `CIU_SILICON_REV;
    error_status[`CIU_ST_DPE_LO +: 4] = data_parity_error_flags;
    error_status[`CIU_ST_TPE_BIT] = tag_parity_error_flag;
    error_status[`CIU_ST_DIRTY_BIT] = err_dirty;
    error_status[`CIU_ST_MEM_BIT] = err_memory;
    error_status[`CIU_ST_MULTI_BIT] = err_multi;
  end

  // Error address view with reserved bits zero
  always_comb begin
    error_address_view = 64'h0;
    error_address_view[36:4] = error_address[36:4];
    error_address_view[39] = error_address[39];
  end

  // Read data register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      reg_rdata <= 64'h0;
    else if (status_read)
      reg_rdata <= {32'h0, error_status};
    else if (addr_read)
      reg_rdata <= error_address_view;
    else if (reg_rd)
      reg_rdata <= 64'h0;
  end

  // Cache hit, forced tag write and cache enable
  always_comb begin
    cache_hit = 1'b0;
    tag_write = 1'b0;
    tag_status_out = 3'h0;
    go_to_memory = 1'b0;
    mem_write_blocked = 1'b0;
    if (acc_valid) begin
      if (!cfg[`CIU_CACHE_EN_BIT]) begin
        go_to_memory = !acc_write;
        mem_write_blocked = acc_write;
      end else if (cfg[`CIU_FORCE_HIT_BIT] && !acc_address[`CIU_IO_SPACE_BIT]) begin
        cache_hit = 1'b1;
        tag_write = 1'b1;
        tag_status_out = cfg[`CIU_TAG_DATA_HI:`CIU_TAG_DATA_LO];
      end else begin
        cache_hit = tag_match && !acc_address[`CIU_IO_SPACE_BIT];
        go_to_memory = !cache_hit && !acc_write;
      end
    end
  end

  // Cache sram clock timer
  ciu_clock_delay u_delay (
    .core_clk(core_clk),
    .rstn(rstn),
    .cache_clock_base_delay(cfg[`CIU_CLK_BASE_HI:`CIU_CLK_BASE_LO]),
    .fill_clock_delay_offset(cfg[`CIU_FILL_OFF_HI:`CIU_FILL_OFF_LO]),
    .index_start(index_start),
    .fill_cmd(fill_cmd),
    .cache_sram_clock(cache_sram_clock)
  );

  // Assertions
  property p_capture;
    @(posedge core_clk) disable iff (!rstn)
    (|lw_err && !locked) |=> (data_parity_error_flags == $past(lw_err)
      && error_address == $past(physical_address));
  endproperty
  a_capture: assert property (p_capture) else $error("error not captured");

  property p_lock;
    @(posedge core_clk) disable iff (!rstn)
    (locked && any_err && !status_read) |=> (err_multi
      && error_address == $past(error_address));
  endproperty
  a_lock: assert property (p_lock) else $error("lock not held");

  property p_clear;
    @(posedge core_clk) disable iff (!rstn)
    (status_read && !any_err) |=> (!locked && !err_multi);
  endproperty
  a_clear: assert property (p_clear) else $error("read did not clear");

  property p_addr_zero;
    @(posedge core_clk) disable iff (!rstn)
    addr_read |=> (reg_rdata[3:0] == 4'h0 && reg_rdata[38:37] == 2'h0 && reg_rdata[63:40] == 24'h0);
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("address reserved bits set");

  property p_force_err;
    @(posedge core_clk) disable iff (!rstn)
    cfg[`CIU_FORCE_ERR_BIT] |-> (wr_data_out[0] != wr_data_in[0] && wr_data_out[96] != wr_data_in[96]);
  endproperty
  a_force_err: assert property (p_force_err) else $error("bit zero not inverted");

  property p_force_hit;
    @(posedge core_clk) disable iff (!rstn)
    (acc_valid && cfg[`CIU_CACHE_EN_BIT] && cfg[`CIU_FORCE_HIT_BIT]
      && !acc_address[`CIU_IO_SPACE_BIT]) |-> (cache_hit && tag_status_out == cfg[30:28]);
  endproperty
  a_force_hit: assert property (p_force_hit) else $error("forced hit missing");

  property p_disabled;
    @(posedge core_clk) disable iff (!rstn)
    (acc_valid && !cfg[`CIU_CACHE_EN_BIT]) |-> (!cache_hit && (acc_write ? mem_write_blocked : go_to_memory));
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled cache hit");

  property p_status_low;
    @(posedge core_clk) disable iff (!rstn)
    status_read |=> (reg_rdata[3:0] == 4'h0 && reg_rdata[11:8] == `CIU_SILICON_REV);
  endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits wrong");

  property p_ratio_hold;
    @(posedge core_clk) disable iff (!rstn)
    (ratio_wait == 2'h3) |=> $stable(system_clock_ratio);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("clock ratio changed");
endmodule : ciu_regs
`default_nettype wire

// file: tb_ciu_regs.sv
// Self-checking testbench for the cache interface unit register bank
`timescale 1ns/1ps
`default_nettype none
`include "ciu_consts.svh"
module tb_top;
  // Clock, reset and inputs of the block
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [39:0] reg_addr = 40'h0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic cfg_wr = 1'b0;
  logic [3:0] irq_pins = 4'h5;
  logic rd_valid = 1'b0;
  logic [39:0] physical_address = 40'h0;
  logic [127:0] rd_data = 128'h0;
  logic [3:0] rd_parity = 4'h0;
  logic rd_fill = 1'b0;
  logic tag_valid = 1'b0;
  logic [2:0] tag_status_in = 3'h0;
  logic tag_match = 1'b0;
  logic acc_valid = 1'b0;
  logic acc_write = 1'b0;
  logic acc_instr = 1'b0;
  logic [39:0] acc_address = 40'h0;
  logic [127:0] wr_data_in = 128'h0;
  logic index_start = 1'b0;
  logic fill_cmd = 1'b0;
  // Outputs of the block
  logic [63:0] reg_rdata;
  logic [31:0] cfg_rdata;
  logic cache_hit, go_to_memory, mem_write_blocked, tag_write, cache_sram_clock;
  logic [2:0] tag_status_out;
  logic [127:0] wr_data_out;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  ciu_regs dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(1'b0), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_wr(cfg_wr),
    .cfg_rdata(cfg_rdata), .irq_pins(irq_pins), .rd_valid(rd_valid),
    .physical_address(physical_address), .rd_data(rd_data), .rd_parity(rd_parity),
    .rd_fill(rd_fill), .tag_valid(tag_valid), .tag_status_in(tag_status_in),
    .tag_match(tag_match), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_instr(acc_instr), .acc_address(acc_address), .wr_data_in(wr_data_in),
    .cache_hit(cache_hit), .go_to_memory(go_to_memory), .mem_write_blocked(mem_write_blocked),
    .tag_write(tag_write), .tag_status_out(tag_status_out), .wr_data_out(wr_data_out),
    .index_start(index_start), .fill_cmd(fill_cmd), .cache_sram_clock(cache_sram_clock));
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  // Cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // Compare one value
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic cfg_write(input logic [31:0] d);
    reg_wdata = d;
    cfg_wr = 1'b1;
    step();
    cfg_wr = 1'b0;
    step();
  endtask : cfg_write
  task automatic reg_read(input logic [39:0] a, output logic [63:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    reg_rd = 1'b0;
    d = reg_rdata;
    step();
  endtask : reg_read
  // Returning read with chosen longwords carrying bad even parity
  task automatic inject(input logic [39:0] pa, input logic [3:0] bad, input logic fill,
                        input logic dirty);
    physical_address = pa;
    rd_data = {32'h12345678, 32'h0F0F0F01, 32'hCAFE0003, 32'h00000007};
    for (int i = 0; i < 4; i++) begin
      rd_parity[i] = (^rd_data[32*i +: 32]) ^ bad[i];
    end
    rd_fill = fill;
    tag_status_in = {2'b10, dirty};
    tag_valid = 1'b1;
    rd_valid = 1'b1;
    step();
    rd_valid = 1'b0;
    step();
  endtask : inject
  task automatic t_reset();
    logic [63:0] d;
    check("config", 32'h00104000, cfg_rdata);
    reg_read(`CIU_ERROR_STATUS_OFFS, d);
    check("status", {52'h0, `CIU_SILICON_REV, 8'h50}, d);
    reg_read(`CIU_ERROR_ADDRESS_OFFS, d);
    check("address", 64'h0, d);
    reg_read(40'hFFFFF00000, d);
    check("unmapped", 64'h0, d);
  endtask : t_reset
  task automatic t_config();
    cfg_write(32'hFFFFFFFF);
    check("config all", 32'hF7F0C000, cfg_rdata);
    cfg_write(32'h0);
    check("config none", 32'h0, cfg_rdata);
    measure(1'b0, 1);
    measure(1'b1, 1);
  endtask : t_config
  // Delay from index to cache sram clock pulse
  task automatic measure(input logic fill, input int exp);
    int k;
    k = 1;
    index_start = 1'b1;
    fill_cmd = fill;
    step();
    index_start = 1'b0;
    fill_cmd = 1'b0;
    while (cache_sram_clock !== 1'b1 && k < 20) begin
      step();
      k++;
    end
    check("sram clock delay", exp, k);
    repeat (3) step();
  endtask : measure
  task automatic t_clock();
    cfg_write(32'h00104000);
    measure(1'b1, 3);
    cfg_write(32'h00408000);
    measure(1'b1, 7);
    measure(1'b0, 2);
  endtask : t_clock
  task automatic t_mem_error();
    logic [63:0] d;
    cfg_write(32'h01104000);
    inject(40'h7ABCDEF12C, 4'b0100, 1'b1, 1'b1);
    inject(40'h0100000040, 4'b0001, 1'b0, 1'b0);
    reg_read(`CIU_ERROR_ADDRESS_OFFS, d);
    check("address held", 64'h0000001ABCDEF120, d);
    reg_read(`CIU_ERROR_STATUS_OFFS, d);
    check("status locked", 64'h00000000000E4A50, d);
    reg_read(`CIU_ERROR_STATUS_OFFS, d);
    check("status cleared", 64'h0000000000000A50, d);
    inject(40'h0000000018, 4'b1000, 1'b0, 1'b0);
    reg_read(`CIU_ERROR_ADDRESS_OFFS, d);
    check("address next", 64'h0000000000000010, d);
    reg_read(`CIU_ERROR_STATUS_OFFS, d);
    check("status next", 64'h0000000000008A50, d);
  endtask : t_mem_error
  task automatic t_io_error();
    logic [63:0] d;
    cfg_write(32'h00904000);
    inject(40'h0000000200, 4'b0010, 1'b0, 1'b0);
    reg_read(`CIU_ERROR_STATUS_OFFS, d);
    check("memory unchecked", 64'h0000000000000A50, d);
    inject(40'hE000001234, 4'b0010, 1'b0, 1'b0);
    reg_read(`CIU_ERROR_ADDRESS_OFFS, d);
    check("io address", 64'h0000008000001230, d);
    reg_read(`CIU_ERROR_STATUS_OFFS, d);
    check("io status", 64'h0000000000002A50, d);
  endtask : t_io_error
  task automatic t_cache_ctl();
    cfg_write(32'hD6104000);
    acc_valid = 1'b1;
    acc_write = 1'b1;
    acc_address = 40'h0000001000;
    tag_match = 1'b0;
    tag_valid = 1'b0;
    wr_data_in = 128'h0;
    step();
    check("forced hit", 1'b1, cache_hit);
    check("tag write", 1'b1, tag_write);
    check("tag status", 3'h5, tag_status_out);
    check("corrupt data", {4{32'h00000001}}, wr_data_out);
    check("forced write allowed", 1'b0, mem_write_blocked);
    acc_address = 40'h8000001000;
    step();
    check("io no hit", 1'b0, cache_hit);
    cfg_write(32'h06104000);
    acc_address = 40'h0000001000;
    step();
    check("write blocked", 1'b1, mem_write_blocked);
    check("disabled no hit", 1'b0, cache_hit);
    acc_write = 1'b0;
    acc_instr = 1'b1;
    step();
    check("to memory", 1'b1, go_to_memory);
    cfg_write(32'h80104000);
    tag_match = 1'b1;
    tag_valid = 1'b1;
    step();
    check("cached read", 1'b0, go_to_memory);
    check("cached hit", 1'b1, cache_hit);
    acc_write = 1'b1;
    acc_instr = 1'b0;
    wr_data_in = 128'hFFFF0000;
    step();
    check("plain data", 128'hFFFF0000, wr_data_out);
    check("write allowed", 1'b0, mem_write_blocked);
    acc_valid = 1'b0;
    step();
  endtask : t_cache_ctl
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (4) step();
    t_reset();
    t_clock();
    t_config();
    t_mem_error();
    t_io_error();
    t_cache_ctl();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
